// ### hw/sfpd_protect_top.sv
//Contract
//- 4 KB block holds sixteen pages; program 1-256 bytes
//- Pages align on 256-byte boundaries
//- Granularity 4 KB; whole array protectable
//- Range scheme only while scheme select clear
//- Complement bit inverts protected region
//- Unit size picks 64 KB or 4 KB steps
//- Bottom bit anchors region at address zero
//- Protected addresses refuse program and erase
//- Level zero without complement protects nothing
//- Top 64 KB steps: 070000h, 060000h, 040000h
//- Bottom 64 KB steps end 00FFFFh..03FFFFh
//- Top 4 KB steps from 07F000h down
//- Bottom 4 KB steps end 000FFFh upward
//- Complement, top 64 KB steps table
//- Complement, bottom 64 KB steps table
//- Complement, top 4 KB steps table
//- Complement, bottom 4 KB steps table
//- 32/64 KB erases use coarser complemented 4 KB-unit region
`timescale 1ns/1ns
`default_nettype none
module sfpd_protect_top (
  input  wire logic                   i_clk,
  input  wire logic                   i_sys_rst,
  input  wire logic                   i_psel,
  input  wire logic                   i_penable,
  input  wire logic                   i_pwrite,
  input  wire logic [11:0]            i_paddr,
  input  wire logic [31:0]            i_pwdata,
  input  wire logic [3:0]             i_pstrb,
  output logic [31:0]                 o_prdata,
  output logic                        o_pready,
  output logic                        o_pslverr,
  output logic                        o_op_valid,
  output logic                        o_op_reject,
  output sfpd_pkg::sfpd_op_type       o_op_kind,
  output logic [18:0]                 o_op_addr,
  output logic [8:0]                  o_op_len
);
  sfpd_pkg::sfpd_state_type state;
  logic [6:0]               cfg;
  logic [18:0]              addr_reg;
  logic [6:0]               snap_cfg;
  logic [18:0]              snap_addr;
  sfpd_pkg::sfpd_op_type    snap_op;
  logic [8:0]               snap_len;
  logic                     last_grant;
  logic                     last_prot;
  logic                     last_len;
  logic [15:0]              rej_count;
  logic                     setup;
  logic                     access;
  logic                     mapped;
  logic                     err_q;
  logic                     wr_cfg;
  logic                     wr_addr;
  logic                     wr_cmd;
  logic                     dec_protected;
  logic                     page_fits;
  logic                     len_ok;
  logic                     grant;
  logic [31:0]              next_prdata;
  logic                     next_err;

  assign setup    = i_psel && !i_penable;
  assign access   = i_psel && i_penable;
  assign mapped   = (i_paddr == sfpd_pkg::OFF_CFG) || (i_paddr == sfpd_pkg::OFF_ADDR) ||
                    (i_paddr == sfpd_pkg::OFF_CMD) || (i_paddr == sfpd_pkg::OFF_STATUS);
  // Zero wait states: data and error are prepared during the setup cycle
  assign o_pready = 1'b1;
  assign wr_cfg   = access && i_pwrite && !err_q && (i_paddr == sfpd_pkg::OFF_CFG) && i_pstrb[0];
  assign wr_addr  = access && i_pwrite && !err_q && (i_paddr == sfpd_pkg::OFF_ADDR);
  assign wr_cmd   = access && i_pwrite && !err_q && (i_paddr == sfpd_pkg::OFF_CMD);

  // A command while one is still being checked is refused, not queued
  always_comb begin
    next_err = !mapped || (i_pwrite && (i_paddr == sfpd_pkg::OFF_CMD) && (state == sfpd_pkg::ST_CHECK));
  end

  always_comb begin
    next_prdata = 32'h0000_0000;
    unique case (i_paddr)
      sfpd_pkg::OFF_CFG:  next_prdata[sfpd_pkg::CFG_W-1:0] = cfg;
      sfpd_pkg::OFF_ADDR: next_prdata[sfpd_pkg::ADDR_W-1:0] = addr_reg;
      sfpd_pkg::OFF_CMD: begin
        next_prdata[sfpd_pkg::CMD_OP_LSB +: 2] = snap_op;
        next_prdata[sfpd_pkg::CMD_LEN_LSB +: sfpd_pkg::LEN_W] = snap_len;
      end
      sfpd_pkg::OFF_STATUS: begin
        next_prdata[sfpd_pkg::SB_BUSY_BIT]  = (state == sfpd_pkg::ST_CHECK);
        next_prdata[sfpd_pkg::SB_GRANT_BIT] = last_grant;
        next_prdata[sfpd_pkg::SB_PROT_BIT]  = last_prot;
        next_prdata[sfpd_pkg::SB_LEN_BIT]   = last_len;
        next_prdata[sfpd_pkg::SB_CFG_LSB +: sfpd_pkg::CFG_W] = snap_cfg;
        next_prdata[sfpd_pkg::SB_REJ_LSB +: sfpd_pkg::REJ_W] = rej_count;
      end
      default: next_prdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_prdata <= 32'h0000_0000;
      err_q    <= 1'b0;
    end else if (setup) begin
      o_prdata <= i_pwrite ? 32'h0000_0000 : next_prdata;
      err_q    <= next_err;
    end
  end

  assign o_pslverr = access && err_q;

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cfg <= sfpd_pkg::CFG_RESET;
    end else if (wr_cfg) begin
      cfg <= i_pwdata[sfpd_pkg::CFG_W-1:0];
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      addr_reg <= 19'h00000;
    end else if (wr_addr) begin
      addr_reg <= i_pwdata[sfpd_pkg::ADDR_W-1:0];
    end
  end

  // Settings captured with the command; later writes cannot change its outcome
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      snap_cfg  <= sfpd_pkg::CFG_RESET;
      snap_addr <= 19'h00000;
      snap_op   <= sfpd_pkg::OP_PROGRAM;
      snap_len  <= 9'h000;
    end else if (wr_cmd) begin
      snap_cfg  <= cfg;
      snap_addr <= addr_reg;
      snap_op   <= sfpd_pkg::sfpd_op_type'(i_pwdata[sfpd_pkg::CMD_OP_LSB +: 2]);
      snap_len  <= i_pwdata[sfpd_pkg::CMD_LEN_LSB +: sfpd_pkg::LEN_W];
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state <= sfpd_pkg::ST_IDLE;
    end else begin
      unique case (state)
        sfpd_pkg::ST_IDLE:  state <= wr_cmd ? sfpd_pkg::ST_CHECK : sfpd_pkg::ST_IDLE;
        sfpd_pkg::ST_CHECK: state <= sfpd_pkg::ST_IDLE;
        default:            state <= sfpd_pkg::ST_IDLE;
      endcase
    end
  end

  sfpd_range_decode u_range (
    .i_scheme_sel  (snap_cfg[sfpd_pkg::CFG_SEL_BIT]),
    .i_complement  (snap_cfg[sfpd_pkg::CFG_CMP_BIT]),
    .i_unit_size   (snap_cfg[sfpd_pkg::CFG_SIZE_BIT]),
    .i_from_bottom (snap_cfg[sfpd_pkg::CFG_BOTTOM_BIT]),
    .i_level       (snap_cfg[sfpd_pkg::CFG_LEVEL_LSB +: sfpd_pkg::LEVEL_W]),
    .i_op          (snap_op),
    .i_addr        (snap_addr),
    .o_protected   (dec_protected)
  );

  sfpd_page_check u_page (
    .i_offset (snap_addr[7:0]),
    .i_len    (snap_len),
    .o_fits   (page_fits)
  );

  // Erase length field is ignored; erases cover their aligned block
  assign len_ok = (snap_op != sfpd_pkg::OP_PROGRAM) || page_fits;
  assign grant  = len_ok && !dec_protected;

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_op_valid  <= 1'b0;
      o_op_reject <= 1'b0;
    end else begin
      o_op_valid  <= (state == sfpd_pkg::ST_CHECK) && grant;
      o_op_reject <= (state == sfpd_pkg::ST_CHECK) && !grant;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_op_kind <= sfpd_pkg::OP_PROGRAM;
      o_op_addr <= 19'h00000;
      o_op_len  <= 9'h000;
    end else if (state == sfpd_pkg::ST_CHECK) begin
      o_op_kind <= snap_op;
      o_op_addr <= snap_addr;
      o_op_len  <= snap_len;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      last_grant <= 1'b0;
      last_prot  <= 1'b0;
      last_len   <= 1'b0;
    end else if (state == sfpd_pkg::ST_CHECK) begin
      last_grant <= grant;
      last_prot  <= dec_protected;
      last_len   <= !len_ok;
    end
  end

  // Saturates so software never sees a wrapped count
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rej_count <= 16'h0000;
    end else if ((state == sfpd_pkg::ST_CHECK) && !grant && (rej_count != 16'hffff)) begin
      rej_count <= rej_count + 16'h0001;
    end
  end

  property p_cmd_result;
    @(posedge i_clk) disable iff (i_sys_rst)
    wr_cmd |=> ##1 (o_op_valid ^ o_op_reject);
  endproperty
  a_cmd_result: assert property (p_cmd_result) else $error("command gave no single outcome");

  property p_valid_pulse;
    @(posedge i_clk) disable iff (i_sys_rst)
    o_op_valid |=> !o_op_valid && !o_op_reject;
  endproperty
  a_valid_pulse: assert property (p_valid_pulse) else $error("grant pulse longer than one cycle");

  property p_protect_refuse;
    @(posedge i_clk) disable iff (i_sys_rst)
    (state == sfpd_pkg::ST_CHECK) && dec_protected |=> o_op_reject && !o_op_valid;
  endproperty
  a_protect_refuse: assert property (p_protect_refuse) else $error("protected operation not refused");

  property p_scheme_off;
    @(posedge i_clk) disable iff (i_sys_rst)
    (state == sfpd_pkg::ST_CHECK) && snap_cfg[sfpd_pkg::CFG_SEL_BIT] && len_ok |=> o_op_valid;
  endproperty
  a_scheme_off: assert property (p_scheme_off) else $error("range scheme active while deselected");

  property p_page_bound;
    @(posedge i_clk) disable iff (i_sys_rst)
    o_op_valid && (o_op_kind == sfpd_pkg::OP_PROGRAM) |->
      ({2'b00, o_op_addr[7:0]} + {1'b0, o_op_len} <= sfpd_pkg::PAGE_MAX) && (o_op_len != 9'h000);
  endproperty
  a_page_bound: assert property (p_page_bound) else $error("program crosses page or has no bytes");

  property p_level_zero;
    @(posedge i_clk) disable iff (i_sys_rst)
    (state == sfpd_pkg::ST_CHECK) && !snap_cfg[sfpd_pkg::CFG_CMP_BIT] &&
      (snap_cfg[sfpd_pkg::CFG_LEVEL_LSB +: sfpd_pkg::LEVEL_W] == 3'h0) |-> !dec_protected;
  endproperty
  a_level_zero: assert property (p_level_zero) else $error("level zero protected something");

  property p_top_64k;
    @(posedge i_clk) disable iff (i_sys_rst)
    (state == sfpd_pkg::ST_CHECK) && (snap_cfg == 7'h10) |->
      dec_protected == ({1'b0, snap_addr} >= sfpd_pkg::SPAN_ALL - sfpd_pkg::SPAN_64K);
  endproperty
  a_top_64k: assert property (p_top_64k) else $error("top 64 KB range wrong");

  property p_bottom_4k;
    @(posedge i_clk) disable iff (i_sys_rst)
    (state == sfpd_pkg::ST_CHECK) && (snap_cfg == 7'h1c) |->
      dec_protected == ((snap_op == sfpd_pkg::OP_ERASE_64K) ? ({1'b0, snap_addr} < sfpd_pkg::SPAN_64K) :
                        (snap_op == sfpd_pkg::OP_ERASE_32K) ? ({1'b0, snap_addr} < sfpd_pkg::SPAN_32K) :
                        ({1'b0, snap_addr} < sfpd_pkg::SPAN_4K));
  endproperty
  a_bottom_4k: assert property (p_bottom_4k) else $error("bottom 4 KB range wrong");

  property p_cmp_all;
    @(posedge i_clk) disable iff (i_sys_rst)
    (state == sfpd_pkg::ST_CHECK) && (snap_cfg[3:0] == 4'h2) &&
      (snap_cfg[sfpd_pkg::CFG_LEVEL_LSB +: sfpd_pkg::LEVEL_W] == 3'h0) |=> o_op_reject;
  endproperty
  a_cmp_all: assert property (p_cmp_all) else $error("complement of nothing must refuse all");

  property p_coarse_32k;
    @(posedge i_clk) disable iff (i_sys_rst)
    (state == sfpd_pkg::ST_CHECK) && (snap_cfg == 7'h16) && (snap_op == sfpd_pkg::OP_ERASE_32K) |->
      dec_protected == ({1'b0, snap_addr} < sfpd_pkg::SPAN_ALL - sfpd_pkg::SPAN_32K);
  endproperty
  a_coarse_32k: assert property (p_coarse_32k) else $error("32 KB erase region not coarsened");
endmodule : sfpd_protect_top
`default_nettype wire

// ### hw/sfpd_pkg.sv
`default_nettype none
package sfpd_pkg;
  // Array geometry, byte spans on a 20-bit scale so the full size is representable
  localparam int              ADDR_W     = 19;
  localparam int              SPAN_W     = 20;
  localparam logic [19:0]     SPAN_NONE  = 20'h00000;
  localparam logic [19:0]     SPAN_PAGE  = 20'h00100;
  localparam logic [19:0]     SPAN_4K    = 20'h01000;
  localparam logic [19:0]     SPAN_8K    = 20'h02000;
  localparam logic [19:0]     SPAN_16K   = 20'h04000;
  localparam logic [19:0]     SPAN_32K   = 20'h08000;
  localparam logic [19:0]     SPAN_64K   = 20'h10000;
  localparam logic [19:0]     SPAN_128K  = 20'h20000;
  localparam logic [19:0]     SPAN_256K  = 20'h40000;
  localparam logic [19:0]     SPAN_ALL   = 20'h80000;
  localparam int              LEN_W      = 9;
  localparam logic [9:0]      PAGE_MAX   = 10'h100;
  localparam int              LEVEL_W    = 3;

  // APB register map
  localparam int              APB_ADDR_W = 12;
  localparam logic [11:0]     OFF_CFG    = 12'h000;
  localparam logic [11:0]     OFF_ADDR   = 12'h004;
  localparam logic [11:0]     OFF_CMD    = 12'h008;
  localparam logic [11:0]     OFF_STATUS = 12'h00c;

  // Protection configuration fields
  localparam int              CFG_SEL_BIT    = 0;
  localparam int              CFG_CMP_BIT    = 1;
  localparam int              CFG_SIZE_BIT   = 2;
  localparam int              CFG_BOTTOM_BIT = 3;
  localparam int              CFG_LEVEL_LSB  = 4;
  localparam int              CFG_W          = 7;
  localparam logic [6:0]      CFG_RESET      = 7'h00;

  // Command fields
  localparam int              CMD_OP_LSB  = 0;
  localparam int              CMD_LEN_LSB = 8;

  // Status fields
  localparam int              SB_BUSY_BIT  = 0;
  localparam int              SB_GRANT_BIT = 1;
  localparam int              SB_PROT_BIT  = 2;
  localparam int              SB_LEN_BIT   = 3;
  localparam int              SB_CFG_LSB   = 8;
  localparam int              SB_REJ_LSB   = 16;
  localparam int              REJ_W        = 16;

  typedef enum logic [1:0] {
    OP_PROGRAM   = 2'h0,
    OP_ERASE_4K  = 2'h1,
    OP_ERASE_32K = 2'h2,
    OP_ERASE_64K = 2'h3
  } sfpd_op_type;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'h1,
    ST_CHECK = 2'h2
  } sfpd_state_type;
endpackage : sfpd_pkg
`default_nettype wire

// ### hw/sfpd_page_check.sv
`timescale 1ns/1ns
`default_nettype none
module sfpd_page_check (
  input  wire logic [7:0] i_offset,
  input  wire logic [8:0] i_len,
  output logic            o_fits
);
  logic [9:0] end_excl;

  // A program must stay inside its 256-byte aligned page
  assign end_excl = {2'b00, i_offset} + {1'b0, i_len};
  assign o_fits   = (i_len != 9'h000) && (end_excl <= sfpd_pkg::PAGE_MAX);
endmodule : sfpd_page_check
`default_nettype wire

// ### hw/sfpd_range_decode.sv
`timescale 1ns/1ns
`default_nettype none
module sfpd_range_decode (
  input  wire logic                     i_scheme_sel,
  input  wire logic                     i_complement,
  input  wire logic                     i_unit_size,
  input  wire logic                     i_from_bottom,
  input  wire logic [2:0]               i_level,
  input  wire sfpd_pkg::sfpd_op_type    i_op,
  input  wire logic [18:0]              i_addr,
  output logic                          o_protected
);
  logic [19:0] span;
  logic [19:0] lo;
  logic [19:0] hi;
  logic [19:0] gran;
  logic [19:0] mask;
  logic [19:0] op_lo;
  logic [19:0] op_hi;
  logic        empty;

  // Size of the plain (uncomplemented) range
  always_comb begin
    span = sfpd_pkg::SPAN_NONE;
    if (!i_unit_size) begin
      unique case (i_level)
        3'h1:    span = sfpd_pkg::SPAN_64K;
        3'h2:    span = sfpd_pkg::SPAN_128K;
        3'h3:    span = sfpd_pkg::SPAN_256K;
        3'h4, 3'h5, 3'h6, 3'h7: span = sfpd_pkg::SPAN_ALL;
        default: span = sfpd_pkg::SPAN_NONE;
      endcase
    end else begin
      unique case (i_level)
        3'h1:    span = sfpd_pkg::SPAN_4K;
        3'h2:    span = sfpd_pkg::SPAN_8K;
        3'h3:    span = sfpd_pkg::SPAN_16K;
        3'h4, 3'h5: span = sfpd_pkg::SPAN_32K;
        3'h6, 3'h7: span = sfpd_pkg::SPAN_ALL;
        default: span = sfpd_pkg::SPAN_NONE;
      endcase
    end
  end

  always_comb begin
    lo    = sfpd_pkg::SPAN_NONE;
    hi    = sfpd_pkg::SPAN_ALL - 20'h00001;
    empty = 1'b0;
    unique case (i_op)
      sfpd_pkg::OP_ERASE_4K:  gran = sfpd_pkg::SPAN_4K;
      sfpd_pkg::OP_ERASE_32K: gran = sfpd_pkg::SPAN_32K;
      sfpd_pkg::OP_ERASE_64K: gran = sfpd_pkg::SPAN_64K;
      default:                gran = sfpd_pkg::SPAN_PAGE;
    endcase
    mask = ~(gran - 20'h00001);
    if (span == sfpd_pkg::SPAN_NONE) begin
      empty = !i_complement;
    end else if (!i_complement) begin
      if (i_from_bottom) begin
        hi = span - 20'h00001;
      end else begin
        lo = sfpd_pkg::SPAN_ALL - span;
      end
    end else if (span == sfpd_pkg::SPAN_ALL) begin
      empty = 1'b1;
    end else if (i_from_bottom) begin
      lo = span;
    end else begin
      hi = sfpd_pkg::SPAN_ALL - span - 20'h00001;
    end
    // 32 KB and 64 KB erases see the complemented 4 KB-unit region trimmed to their own grain
    if (i_complement && i_unit_size && !empty &&
        (i_op == sfpd_pkg::OP_ERASE_32K || i_op == sfpd_pkg::OP_ERASE_64K)) begin
      if (i_from_bottom) begin
        lo = (lo + gran - 20'h00001) & mask;
      end else if (((hi + 20'h00001) & mask) == sfpd_pkg::SPAN_NONE) begin
        empty = 1'b1;
      end else begin
        hi = ((hi + 20'h00001) & mask) - 20'h00001;
      end
    end
    op_lo = {1'b0, i_addr} & mask;
    op_hi = op_lo | ~mask;
  end

  // Any overlap with the protected region refuses the whole operation
  assign o_protected = !i_scheme_sel && !empty && (op_lo <= hi) && (op_hi >= lo);
endmodule : sfpd_range_decode
`default_nettype wire

// ### verif/sfpd_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module sfpd_host_model (
  input  wire logic        i_clk,
  input  wire logic [31:0] i_prdata,
  input  wire logic        i_pready,
  input  wire logic        i_pslverr,
  output logic             o_psel,
  output logic             o_penable,
  output logic             o_pwrite,
  output logic [11:0]      o_paddr,
  output logic [31:0]      o_pwdata,
  output logic [3:0]       o_pstrb
);
  initial begin
    o_psel    = 1'b0;
    o_penable = 1'b0;
    o_pwrite  = 1'b0;
    o_paddr   = 12'h000;
    o_pwdata  = 32'h0000_0000;
    o_pstrb   = 4'hf;
  end

  // One transfer; a hang is left to the bench watchdog
  task automatic xfer(input logic wr, input logic [11:0] addr, input logic [31:0] data,
                      output logic [31:0] rdata, output logic err);
    @(posedge i_clk);
    o_psel    <= 1'b1;
    o_penable <= 1'b0;
    o_pwrite  <= wr;
    o_paddr   <= addr;
    o_pwdata  <= data;
    @(posedge i_clk);
    o_penable <= 1'b1;
    do begin
      @(posedge i_clk);
    end while (i_pready !== 1'b1);
    rdata = i_prdata;
    err   = i_pslverr;
    o_psel    <= 1'b0;
    o_penable <= 1'b0;
    // Released lines change so stale values are never mistaken for held ones
    o_pwrite  <= ~wr;
    o_paddr   <= ~addr;
    o_pwdata  <= ~data;
  endtask : xfer
endmodule : sfpd_host_model
`default_nettype wire

// ### verif/serial_flash_block_protect_decode_test.sv
`timescale 1ns/1ns
`default_nettype none
module serial_flash_block_protect_decode_test;
  logic                  i_clk;
  logic                  i_sys_rst;
  logic                  psel;
  logic                  penable;
  logic                  pwrite;
  logic [11:0]           paddr;
  logic [31:0]           pwdata;
  logic [3:0]            pstrb;
  logic [31:0]           o_prdata;
  logic                  o_pready;
  logic                  o_pslverr;
  logic                  o_op_valid;
  logic                  o_op_reject;
  sfpd_pkg::sfpd_op_type o_op_kind;
  logic [18:0]           o_op_addr;
  logic [8:0]            o_op_len;
  logic [31:0]           rd;
  logic                  er;
  int                    num_errors = 0;
  int                    num_checks = 0;
  int                    num_rej = 0;

  sfpd_protect_top uut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .o_op_valid(o_op_valid), .o_op_reject(o_op_reject),
    .o_op_kind(o_op_kind), .o_op_addr(o_op_addr), .o_op_len(o_op_len));

  sfpd_host_model host (.i_clk(i_clk), .i_prdata(o_prdata), .i_pready(o_pready), .i_pslverr(o_pslverr),
    .o_psel(psel), .o_penable(penable), .o_pwrite(pwrite), .o_paddr(paddr), .o_pwdata(pwdata),
    .o_pstrb(pstrb));

  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end

  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // Reference region: contiguous, so a complement is just the other end's span
  function automatic logic ref_prot(input logic [6:0] cfg, input logic [1:0] op, input logic [18:0] addr);
    logic [19:0] span;
    logic [19:0] sz;
    logic [19:0] a;
    logic [2:0]  lvl;
    logic        bottom;
    lvl = cfg[6:4];
    sz = (op == 2'h0) ? 20'h00100 : (op == 2'h1) ? 20'h01000 : (op == 2'h2) ? 20'h08000 : 20'h10000;
    if (cfg[2])
      span = (lvl == 3'h0) ? 20'h0 : (lvl < 3'h4) ? 20'h01000 << (lvl - 3'h1) : (lvl < 3'h6) ? 20'h08000 : 20'h80000;
    else
      span = (lvl == 3'h0) ? 20'h0 : (lvl < 3'h4) ? 20'h10000 << (lvl - 3'h1) : 20'h80000;
    bottom = cfg[3];
    if (cfg[1]) begin
      if (cfg[2] && op[1] && span != 20'h0 && span < sz) span = sz;
      span = 20'h80000 - span;
      bottom = !cfg[3];
    end
    if (cfg[0] || span == 20'h0) return 1'b0;
    a = {1'b0, addr} & ~(sz - 20'h1);
    if (bottom) return a < span;
    return a + sz > 20'h80000 - span;
  endfunction : ref_prot

  task automatic run_cmd(input logic [1:0] op, input logic [18:0] addr, input logic [8:0] len, input logic rej);
    host.xfer(1'b1, 12'h004, {13'h0, addr}, rd, er);
    host.xfer(1'b1, 12'h008, {15'h0, len, 6'h0, op}, rd, er);
    // Outcome pulse stands only in the cycle after the check cycle
    @(posedge i_clk);
    #1;
    chk(32'({o_op_valid, o_op_reject}), 32'({!rej, rej}), "outcome");
    chk(32'(o_op_kind), 32'(op), "kind");
    if (op == 2'h0) begin
      chk(32'({o_op_addr, o_op_len}), 32'({addr, len}), "program target");
    end
  endtask : run_cmd

  task automatic test_regs();
    host.xfer(1'b0, 12'h000, 32'h0, rd, er);
    chk(rd, 32'h0, "cfg reset");
    host.xfer(1'b1, 12'h000, 32'hffff_ffff, rd, er);
    host.xfer(1'b0, 12'h000, 32'h0, rd, er);
    chk(32'(rd[6:0]), 32'h7f, "cfg readback");
    host.xfer(1'b0, 12'h010, 32'h0, rd, er);
    chk(32'({er, rd[30:0]}), 32'h8000_0000, "unmapped");
    host.xfer(1'b1, 12'h00c, 32'h0, rd, er);
    chk(32'(er), 32'h0, "status write");
  endtask : test_regs

  task automatic test_table();
    logic [18:0] probes [20];
    logic [6:0]  cfg;
    logic        rej;
    probes = '{19'h00000, 19'h00f00, 19'h01000, 19'h03f00, 19'h07f00, 19'h08000, 19'h0ff00, 19'h10000,
               19'h1ff00, 19'h3ff00, 19'h40000, 19'h5ff00, 19'h6ff00, 19'h70000, 19'h77f00, 19'h7bf00,
               19'h7df00, 19'h7ef00, 19'h7f000, 19'h7ff00};
    cfg = 7'h0;
    for (int c = 0; c < 64; c++) begin
      cfg = {c[5:0], 1'b0};
      host.xfer(1'b1, 12'h000, {25'h0, cfg}, rd, er);
      for (int op = 0; op < 4; op++) begin
        for (int p = 0; p < 20; p++) begin
          rej = ref_prot(cfg, op[1:0], probes[p]);
          num_rej += int'(rej);
          run_cmd(op[1:0], probes[p], 9'h001, rej);
        end
      end
    end
    host.xfer(1'b0, 12'h00c, 32'h0, rd, er);
    chk(32'(rd[14:8]), 32'(cfg), "cfg snapshot");
    chk(32'(rd[31:16]), 32'(num_rej[15:0]), "refused count");
  endtask : test_table

  task automatic test_len();
    host.xfer(1'b1, 12'h000, 32'h0, rd, er);
    run_cmd(2'h0, 19'h7ff00, 9'h100, 1'b0);
    run_cmd(2'h0, 19'h7ff01, 9'h100, 1'b1);
    run_cmd(2'h0, 19'h000ff, 9'h001, 1'b0);
    run_cmd(2'h0, 19'h00000, 9'h000, 1'b1);
    run_cmd(2'h0, 19'h000ff, 9'h002, 1'b1);
    host.xfer(1'b0, 12'h00c, 32'h0, rd, er);
    chk(32'(rd[3:1]), 32'h4, "length flag");
  endtask : test_len

  task automatic test_scheme();
    host.xfer(1'b1, 12'h000, 32'h71, rd, er);
    run_cmd(2'h0, 19'h00000, 9'h010, 1'b0);
    run_cmd(2'h3, 19'h7ff00, 9'h000, 1'b0);
    host.xfer(1'b1, 12'h000, 32'h03, rd, er);
    run_cmd(2'h1, 19'h40000, 9'h000, 1'b0);
    host.xfer(1'b1, 12'h000, 32'h70, rd, er);
    run_cmd(2'h2, 19'h40000, 9'h000, 1'b1);
  endtask : test_scheme

  initial begin
    i_sys_rst = 1'b1;
    repeat (3) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    test_regs();
    test_table();
    test_len();
    test_scheme();
    report_and_stop();
  end

  // Full run is near 36100 cycles
  initial begin
    repeat (80000) @(posedge i_clk);
    num_errors++;
    report_and_stop();
  end
endmodule : serial_flash_block_protect_decode_test
`default_nettype wire
